// ==== rtl/kef_top.sv ====
// key event queue with register access crossing from the link clock
//
// Behaviour
// [R1] queue holds at most ten byte entries
// [R2] member matrix key presses/releases get queued
// [R3] input transitions queued only when mode bit set
// [R4] queuing sets key or input status flag
// [R5] count register low nibble shows occupancy
// [R6] head register: press bit, seven-bit code
// [R7] head read pops and shifts entries forward
// [R8] empty queue reads count zero, head zero
// [R9] host polls status, count, pops, then clears
// [R10] writing one clears that status flag
// [R11] new event with ten queued and no same-cycle pop is overflow
// [R12] overflow sets flag; alert only if enabled
// [R13] policy one: evict oldest, append new
// [R14] policy zero: drop new, keep contents
// [R15] matrix code is row tens, column ones
// [R16] input codes 97-104 rows, 105-114 columns
// [R17] events leave in arrival order
// [R18] alert held while any enabled flag set
`timescale 1ns/10ps
`default_nettype none
module kef_top (
    // core clock and reset
    input wire logic clk,
    input wire logic nrst,
    // link clock and its reset
    input wire logic link_clk,
    input wire logic link_nrst,
    // register access, link domain
    input wire logic lk_req,
    input wire kef_pkg::kef_req_type lk_req_data,
    output logic lk_busy,
    output logic lk_ack,
    output logic [7:0] lk_rdata,
    // matrix scanner events, core domain
    input wire logic key_valid,
    input wire logic key_press,
    input wire logic [2:0] key_row,
    input wire logic [3:0] key_col,
    // general purpose input pins, asynchronous
    input wire logic [17:0] gpi_pin,
    // open-drain alert pin
    output logic alert_out,
    output logic alert_oe
);
    // link domain state
    kef_pkg::kef_req_type lk_req_r;
    logic lk_busy_r;
    logic lk_ack_r;
    logic [7:0] lk_rdata_r;
    logic req_tgl_r;
    logic ack_s1_r, ack_s2_r, ack_s3_r;
    // core domain crossing state
    logic req_s1_r, req_s2_r, req_s3_r;
    logic ack_tgl_r;
    logic [7:0] xfer_rdata_r;
    // register state
    logic [7:0] cfg_r;
    logic [7:0] status_r;
    logic lock_r;
    logic [17:0] member_r;
    logic [17:0] mode_r;
    // queue state
    logic [3:0] count_r;
    kef_pkg::kef_event_type slot_q [kef_pkg::DEPTH];
    // input pin synchronisers
    logic [17:0] gpi_s1_r, gpi_s2_r, gpi_s3_r;
    logic [1:0] settle_r;
    logic [17:0] pend_r;
    // alert
    logic alert_oe_r;

    // ---------------- link domain ----------------
    // take a request only while idle; hold it stable until the answer
    always_ff @(posedge link_clk) begin
        if (!link_nrst) begin
            lk_req_r <= '0;
            req_tgl_r <= 1'b0;
        end else if (lk_req && !lk_busy_r) begin
            lk_req_r <= lk_req_data;
            req_tgl_r <= ~req_tgl_r;
        end
    end

    // answer toggle synchroniser; s1 feeds only s2
    always_ff @(posedge link_clk) begin
        if (!link_nrst) begin
            ack_s1_r <= 1'b0;
            ack_s2_r <= 1'b0;
            ack_s3_r <= 1'b0;
        end else begin
            ack_s1_r <= ack_tgl_r;
            ack_s2_r <= ack_s1_r;
            ack_s3_r <= ack_s2_r;
        end
    end

    // busy from acceptance until the answer toggle arrives
    always_ff @(posedge link_clk) begin
        if (!link_nrst) begin
            lk_busy_r <= 1'b0;
        end else if (ack_s2_r != ack_s3_r) begin
            lk_busy_r <= 1'b0;
        end else if (lk_req) begin
            lk_busy_r <= 1'b1;
        end
    end

    // read data is stable in the core domain when the toggle lands
    always_ff @(posedge link_clk) begin
        if (!link_nrst) begin
            lk_ack_r <= 1'b0;
            lk_rdata_r <= 8'h00;
        end else begin
            lk_ack_r <= (ack_s2_r != ack_s3_r);
            if (ack_s2_r != ack_s3_r) begin
                lk_rdata_r <= xfer_rdata_r;
            end
        end
    end

    assign lk_busy = lk_busy_r;
    assign lk_ack = lk_ack_r;
    assign lk_rdata = lk_rdata_r;

    // ---------------- core domain crossing ----------------
    // request toggle synchroniser; s1 feeds only s2
    always_ff @(posedge clk) begin
        if (!nrst) begin
            req_s1_r <= 1'b0;
            req_s2_r <= 1'b0;
            req_s3_r <= 1'b0;
        end else begin
            req_s1_r <= req_tgl_r;
            req_s2_r <= req_s1_r;
            req_s3_r <= req_s2_r;
        end
    end

    logic acc;
    logic acc_wr;
    logic acc_rd;
    logic [7:0] rd_val;
    logic head_pop;
    // one access executes per toggle; request fields are frozen meanwhile
    assign acc = req_s2_r ^ req_s3_r;
    assign acc_wr = acc & lk_req_r.wr;
    assign acc_rd = acc & ~lk_req_r.wr;
    // popping an empty queue does nothing
    assign head_pop = acc_rd && (lk_req_r.addr == kef_pkg::ADDR_HEAD)
        && (count_r != kef_pkg::CNT_ZERO); // see [R7]

    // read multiplexer; unmapped offsets read zero
    always_comb begin
        rd_val = 8'h00;
        case (lk_req_r.addr)
            kef_pkg::ADDR_CFG: rd_val = cfg_r;
            kef_pkg::ADDR_STATUS: rd_val = status_r;
            kef_pkg::ADDR_COUNT: begin
                rd_val = {1'b0, lock_r, 2'b00, count_r}; // see [R5] [R8]
            end
            // slot 0 is zero once vacated, so empty reads zero
            kef_pkg::ADDR_HEAD: rd_val = slot_q[0]; // see [R6] [R8]
            kef_pkg::ADDR_MEMBER0: rd_val = member_r[7:0];
            kef_pkg::ADDR_MEMBER1: rd_val = member_r[15:8];
            kef_pkg::ADDR_MEMBER2: rd_val = {6'h00, member_r[17:16]};
            kef_pkg::ADDR_MODE0: rd_val = mode_r[7:0];
            kef_pkg::ADDR_MODE1: rd_val = mode_r[15:8];
            kef_pkg::ADDR_MODE2: rd_val = {6'h00, mode_r[17:16]};
            default: rd_val = 8'h00;
        endcase
    end

    // answer: read value captured with the head before any pop
    always_ff @(posedge clk) begin
        if (!nrst) begin
            xfer_rdata_r <= 8'h00;
            ack_tgl_r <= 1'b0;
        end else if (acc) begin
            xfer_rdata_r <= acc_rd ? rd_val : 8'h00;
            ack_tgl_r <= ~ack_tgl_r;
        end
    end

    // writable configuration; reserved bits stay zero
    always_ff @(posedge clk) begin
        if (!nrst) begin
            cfg_r <= kef_pkg::CFG_RESET;
            lock_r <= 1'b0;
            member_r <= '0;
            mode_r <= '0;
        end else if (acc_wr) begin
            case (lk_req_r.addr)
                kef_pkg::ADDR_CFG: cfg_r <= lk_req_r.wdata & kef_pkg::CFG_MASK;
                kef_pkg::ADDR_COUNT: lock_r <= lk_req_r.wdata[kef_pkg::LOCK_BIT];
                kef_pkg::ADDR_MEMBER0: member_r[7:0] <= lk_req_r.wdata;
                kef_pkg::ADDR_MEMBER1: member_r[15:8] <= lk_req_r.wdata;
                kef_pkg::ADDR_MEMBER2: begin
                    member_r[17:16] <= lk_req_r.wdata[1:0];
                end
                kef_pkg::ADDR_MODE0: mode_r[7:0] <= lk_req_r.wdata;
                kef_pkg::ADDR_MODE1: mode_r[15:8] <= lk_req_r.wdata;
                kef_pkg::ADDR_MODE2: mode_r[17:16] <= lk_req_r.wdata[1:0];
                default: begin
                end
            endcase
        end
    end

    // ---------------- event sources ----------------
    // pins are asynchronous: two flops before any logic, third for edges
    always_ff @(posedge clk) begin
        if (!nrst) begin
            gpi_s1_r <= '0;
            gpi_s2_r <= '0;
            gpi_s3_r <= '0;
        end else begin
            gpi_s1_r <= gpi_pin;
            gpi_s2_r <= gpi_s1_r;
            gpi_s3_r <= gpi_s2_r;
        end
    end

    // edges are ignored until the chain holds real pin values
    always_ff @(posedge clk) begin
        if (!nrst) begin
            settle_r <= 2'h0;
        end else if (settle_r != kef_pkg::SYNC_SETTLE) begin
            settle_r <= settle_r + 2'h1;
        end
    end

    logic [17:0] gpi_edge;
    assign gpi_edge = (settle_r == kef_pkg::SYNC_SETTLE) ?
        ((gpi_s2_r ^ gpi_s3_r) & mode_r) : '0; // see [R3]

    // matrix event accepted only for member row and column
    logic key_ok;
    assign key_ok = key_valid && (key_col < kef_pkg::NCOLS)
        && member_r[key_row]
        && member_r[kef_pkg::ROW_PINS + 32'(key_col)]; // see [R2]

    // lowest pending input wins; matrix events go first
    logic gpi_any;
    logic [4:0] gpi_idx;
    always_comb begin
        gpi_any = 1'b0;
        gpi_idx = 5'h00;
        for (int i = kef_pkg::NPINS - 1; i >= 0; i--) begin
            if (pend_r[i]) begin
                gpi_any = 1'b1;
                gpi_idx = 5'(i);
            end
        end
    end

    logic gpi_take;
    logic [17:0] gpi_grant;
    assign gpi_take = gpi_any & ~key_ok;
    assign gpi_grant = gpi_take ? (18'h00001 << gpi_idx) : '0;

    // pending inputs; a new edge survives its own grant cycle
    always_ff @(posedge clk) begin
        if (!nrst) begin
            pend_r <= '0;
        end else begin
            pend_r <= (pend_r & ~gpi_grant) | gpi_edge;
        end
    end

    // event formation
    logic push;
    kef_pkg::kef_event_type push_data;
    always_comb begin
        push = key_ok | gpi_take;
        push_data = '0;
        if (key_ok) begin
            push_data.press = key_press;
            push_data.code = 7'(key_row) * kef_pkg::ROW_WEIGHT
                + 7'(key_col); // see [R15]
        end else if (gpi_take) begin
            // current level: high is a press
            push_data.press = gpi_s3_r[gpi_idx];
            push_data.code = kef_pkg::INPUT_CODE_BASE + 7'(gpi_idx); // see [R16]
        end
    end

    // ---------------- queue ----------------
    logic full;
    logic overflow;
    logic evict;
    logic push_ok;
    logic shift;
    logic [3:0] tail;
    assign full = (count_r == kef_pkg::DEPTH_CNT); // see [R1]
    // a same-cycle pop makes room, so that is no overflow
    assign overflow = push & full & ~head_pop; // see [R11]
    assign evict = overflow & cfg_r[kef_pkg::CFG_OVR_POLICY]; // see [R13]
    // policy zero: the new entry is simply not loaded
    assign push_ok = push & (~overflow | evict); // see [R14]
    assign shift = head_pop | evict; // see [R7]
    assign tail = shift ? (count_r - kef_pkg::CNT_ONE) : count_r;

    // slots shift toward the head; the new entry lands behind the rest
    for (genvar g = 0; g < kef_pkg::DEPTH; g++) begin : g_slot
        kef_pkg::kef_event_type nxt;
        if (g == kef_pkg::DEPTH - 1) begin : g_last
            assign nxt = '0;
        end else begin : g_mid
            assign nxt = slot_q[g + 1];
        end
        kef_slot u_slot (
            .clk(clk),
            .nrst(nrst),
            .shift_en(shift),
            .load_en(push_ok && (tail == 4'(g))), // see [R17]
            .load_data(push_data),
            .next_data(nxt),
            .q(slot_q[g])
        );
    end

    // occupancy: eviction keeps ten
    always_ff @(posedge clk) begin
        if (!nrst) begin
            count_r <= kef_pkg::CNT_ZERO;
        end else if (push_ok && !shift) begin
            count_r <= count_r + kef_pkg::CNT_ONE; // see [R5]
        end else if (head_pop && !push_ok) begin
            count_r <= count_r - kef_pkg::CNT_ONE; // see [R7]
        end
    end

    // ---------------- status and alert ----------------
    logic [7:0] st_set;
    logic [7:0] st_clr;
    always_comb begin
        st_set = 8'h00;
        st_set[kef_pkg::ST_KEY] = key_ok; // see [R4]
        st_set[kef_pkg::ST_INPUT] = gpi_take; // see [R4]
        st_set[kef_pkg::ST_OVR] = overflow; // see [R12]
        st_clr = 8'h00;
        if (acc_wr && lk_req_r.addr == kef_pkg::ADDR_STATUS) begin
            st_clr = lk_req_r.wdata & kef_pkg::ST_MASK; // see [R10]
        end
    end

    // write one clears; a set in the same cycle wins
    always_ff @(posedge clk) begin
        if (!nrst) begin
            status_r <= 8'h00;
        end else begin
            status_r <= (status_r & ~st_clr) | st_set; // see [R10]
        end
    end

    // enabled flags hold the pin low; release once all are cleared
    logic [7:0] ien;
    always_comb begin
        ien = 8'h00;
        ien[kef_pkg::ST_KEY] = cfg_r[kef_pkg::CFG_KEY_IEN];
        ien[kef_pkg::ST_INPUT] = cfg_r[kef_pkg::CFG_INPUT_IEN];
        ien[kef_pkg::ST_OVR] = cfg_r[kef_pkg::CFG_OVR_IEN]; // see [R12]
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            alert_oe_r <= 1'b0;
        end else begin
            alert_oe_r <= |(status_r & ien); // see [R18]
        end
    end

    // open drain: only ever drives low
    assign alert_out = 1'b0;
    assign alert_oe = alert_oe_r;
endmodule
`default_nettype wire

// ==== shared/kef_pkg.sv ====
// package: key event queue constants, register map and carrier types
package kef_pkg;
    // queue geometry
    localparam int unsigned DEPTH = 10;
    localparam logic [3:0] DEPTH_CNT = 4'ha;
    localparam logic [3:0] CNT_ZERO = 4'h0;
    localparam logic [3:0] CNT_ONE = 4'h1;
    // register offsets
    localparam logic [7:0] ADDR_CFG = 8'h01;
    localparam logic [7:0] ADDR_STATUS = 8'h02;
    localparam logic [7:0] ADDR_COUNT = 8'h03;
    localparam logic [7:0] ADDR_HEAD = 8'h04;
    localparam logic [7:0] ADDR_MEMBER0 = 8'h20;
    localparam logic [7:0] ADDR_MEMBER1 = 8'h21;
    localparam logic [7:0] ADDR_MEMBER2 = 8'h22;
    localparam logic [7:0] ADDR_MODE0 = 8'h23;
    localparam logic [7:0] ADDR_MODE1 = 8'h24;
    localparam logic [7:0] ADDR_MODE2 = 8'h25;
    // config fields
    localparam int unsigned CFG_KEY_IEN = 0;
    localparam int unsigned CFG_INPUT_IEN = 1;
    localparam int unsigned CFG_OVR_IEN = 3;
    localparam int unsigned CFG_OVR_POLICY = 5;
    localparam logic [7:0] CFG_MASK = 8'h2b;
    localparam logic [7:0] CFG_RESET = 8'h00;
    // status fields
    localparam int unsigned ST_KEY = 0;
    localparam int unsigned ST_INPUT = 1;
    localparam int unsigned ST_OVR = 3;
    localparam logic [7:0] ST_MASK = 8'h0b;
    // count register fields
    localparam int unsigned LOCK_BIT = 6;
    // top byte of the 18-bit pin maps holds only two columns
    localparam logic [7:0] TOP_BYTE_MASK = 8'h03;
    // pins: rows 0..7 then columns 0..9
    localparam int unsigned NPINS = 18;
    localparam int unsigned ROW_PINS = 8;
    localparam logic [6:0] INPUT_CODE_BASE = 7'd97;
    localparam logic [6:0] ROW_WEIGHT = 7'd10;
    localparam logic [3:0] NCOLS = 4'ha;
    localparam logic [1:0] SYNC_SETTLE = 2'h3;

    // one queue entry
    typedef struct packed {
        logic press;
        logic [6:0] code;
    } kef_event_type;

    // one register access from the link side
    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } kef_req_type;
endpackage

// ==== rtl/kef_slot.sv ====
// one queue slot: shifts toward the head or loads a new entry
`timescale 1ns/10ps
`default_nettype none
module kef_slot (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // control
    input wire logic shift_en,
    input wire logic load_en,
    // data
    input wire kef_pkg::kef_event_type load_data,
    input wire kef_pkg::kef_event_type next_data,
    output kef_pkg::kef_event_type q
);
    // load wins: the tail slot after a shift takes the new entry
    always_ff @(posedge clk) begin
        if (!nrst) begin
            q <= '0;
        end else if (load_en) begin
            q <= load_data;
        end else if (shift_en) begin
            q <= next_data;
        end
    end
endmodule
`default_nettype wire

// ==== testbench/kef_top_chk.sv ====
// checker: link handshake and alert pin relations of the key event queue
`timescale 1ns/10ps
`default_nettype none
module kef_top_chk (
    // core clock and reset
    input wire logic clk,
    input wire logic nrst,
    // link clock and reset
    input wire logic link_clk,
    input wire logic link_nrst,
    // register access
    input wire logic lk_req,
    input wire kef_pkg::kef_req_type lk_req_data,
    input wire logic lk_busy,
    input wire logic lk_ack,
    input wire logic [7:0] lk_rdata,
    // matrix events and pins
    input wire logic key_valid,
    input wire logic key_press,
    input wire logic [2:0] key_row,
    input wire logic [3:0] key_col,
    input wire logic [17:0] gpi_pin,
    // alert pin
    input wire logic alert_out,
    input wire logic alert_oe
);
    a_alert_pin_low: assert property (@(posedge clk) disable iff (!nrst)
        alert_out == 1'b0) else $error("alert level not low");
    a_busy_on_take: assert property (@(posedge link_clk) disable iff (!link_nrst)
        lk_req && !lk_busy |=> lk_busy) else $error("busy missing after take");
    a_ack_in_time: assert property (@(posedge link_clk) disable iff (!link_nrst)
        lk_req && !lk_busy |-> ##[2:11] lk_ack) else $error("answer too late");
    a_ack_single: assert property (@(posedge link_clk) disable iff (!link_nrst)
        lk_ack |=> !lk_ack) else $error("ack longer than one cycle");
    a_busy_till_ack: assert property (@(posedge link_clk) disable iff (!link_nrst)
        $fell(lk_busy) |-> lk_ack) else $error("busy dropped without ack");
    a_ack_not_busy: assert property (@(posedge link_clk) disable iff (!link_nrst)
        lk_ack |-> !lk_busy) else $error("busy during ack");
    a_no_stray_ack: assert property (@(posedge link_clk) disable iff (!link_nrst)
        !lk_busy && !lk_req |=> !lk_ack) else $error("ack without request");
    a_rdata_held: assert property (@(posedge link_clk) disable iff (!link_nrst)
        !lk_ack |-> $stable(lk_rdata)) else $error("read data moved between answers");
    a_write_rd_zero: assert property (@(posedge link_clk) disable iff (!link_nrst)
        lk_req && !lk_busy && lk_req_data.wr |-> ##[2:11] (lk_ack && lk_rdata == 8'h00))
        else $error("write answer not zero");
endmodule
bind kef_top kef_top_chk i_chk (.clk(clk), .nrst(nrst), .link_clk(link_clk),
    .link_nrst(link_nrst), .lk_req(lk_req), .lk_req_data(lk_req_data), .lk_busy(lk_busy),
    .lk_ack(lk_ack), .lk_rdata(lk_rdata), .key_valid(key_valid), .key_press(key_press),
    .key_row(key_row), .key_col(key_col), .gpi_pin(gpi_pin), .alert_out(alert_out),
    .alert_oe(alert_oe));
`default_nettype wire

// ==== testbench/kef_host.sv ====
// host model: issues single register accesses on the link side
`timescale 1ns/10ps
`default_nettype none
module kef_host (
    // link clock and reset
    input wire logic link_clk,
    input wire logic link_nrst,
    // request side
    output var logic lk_req,
    output var kef_pkg::kef_req_type lk_req_data,
    // answer side
    input wire logic lk_busy,
    input wire logic lk_ack
);
    // idle bus until the first access
    initial begin
        lk_req = 1'b0;
        lk_req_data = '0;
    end
    // strobe is one pulse; payload held until the ack edge, then scrambled
    // so that nothing downstream can lean on a stale value
    task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] wdata,
                          input logic [1:0] gap, output logic late);
        int n;
        repeat (int'(gap) + 1) @(posedge link_clk);
        #1;
        lk_req = 1'b1;
        lk_req_data = {wr, addr, wdata};
        @(posedge link_clk);
        #1;
        lk_req = 1'b0;
        n = 0;
        // bounded wait for the answer
        while (lk_ack !== 1'b1 && n < 20) begin
            @(posedge link_clk);
            n++;
        end
        // a missing answer is reported back so the bench can count it
        late = (lk_ack !== 1'b1);
        #1;
        lk_req_data = ~lk_req_data;
    endtask
endmodule
`default_nettype wire

// ==== testbench/kef_top_tb.sv ====
// testbench: key event queue driven by matrix, pins and the host model
`timescale 1ns/10ps
`default_nettype none
module kef_top_tb;
    // clocks, resets, stimulus
    logic clk, nrst, link_clk, link_nrst, key_valid, key_press;
    logic [2:0] key_row;
    logic [3:0] key_col;
    logic [17:0] gpi_pin;
    // link and pin wires
    logic lk_req, lk_busy, lk_ack, alert_out, alert_oe;
    kef_pkg::kef_req_type lk_req_data;
    logic [7:0] lk_rdata;
    // expected answers, oldest first
    logic [7:0] exp_q[$];
    logic [7:0] tbl[10] = '{8'h81, 8'ha0, 8'h01, 8'h20, 8'h97, 8'h17, 8'had, 8'ha9, 8'h29, 8'h2d};
    logic [7:0] rnd[4];
    int errors = 0;
    int n_checks = 0;
    integer seed = 97;
    integer r;

    kef_top i_dut (.clk(clk), .nrst(nrst), .link_clk(link_clk), .link_nrst(link_nrst),
        .lk_req(lk_req), .lk_req_data(lk_req_data), .lk_busy(lk_busy), .lk_ack(lk_ack),
        .lk_rdata(lk_rdata), .key_valid(key_valid), .key_press(key_press), .key_row(key_row),
        .key_col(key_col), .gpi_pin(gpi_pin), .alert_out(alert_out), .alert_oe(alert_oe));
    kef_host i_host (.link_clk(link_clk), .link_nrst(link_nrst), .lk_req(lk_req),
        .lk_req_data(lk_req_data), .lk_busy(lk_busy), .lk_ack(lk_ack));

    // core clock, 10 ns
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // link clock, 32 ns, offset so the phases drift apart
    initial begin
        link_clk = 1'b0;
        #7;
        forever #16 link_clk = ~link_clk;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // register accesses; the answer is noted before the request goes out
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        logic late;
        exp_q.push_back(e);
        r = $random(seed);
        i_host.access(1'b0, a, 8'h00, r[1:0], late);
        check({7'h00, late}, 8'h00);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic late;
        exp_q.push_back(8'h00);
        r = $random(seed);
        i_host.access(1'b1, a, d, r[1:0], late);
        check({7'h00, late}, 8'h00);
    endtask
    // matrix event from an event byte; strobe stays up for back to back use
    task automatic key_ev(input logic [7:0] e);
        @(negedge clk);
        key_valid = 1'b1;
        key_press = e[7];
        key_row = 3'(e[6:0] / 7'd10);
        key_col = 4'(e[6:0] % 7'd10);
    endtask
    task automatic key_end();
        @(negedge clk);
        key_valid = 1'b0;
    endtask
    // alert sampled mid-cycle once status has settled
    task automatic alert_is(input logic v);
        repeat (3) @(negedge clk);
        check({7'h00, alert_oe}, {7'h00, v});
    endtask

    // answer watcher: every ack consumes the oldest note
    always @(posedge link_clk) begin
        if (lk_ack === 1'b1) begin
            check(lk_rdata, exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx);
        end
    end

    // hang guard, far beyond the expected run length
    initial begin
        repeat (50000) @(posedge clk);
        errors++;
        give_verdict();
    end

    initial begin
        nrst = 1'b0;
        link_nrst = 1'b0;
        key_valid = 1'b0;
        key_press = 1'b0;
        key_row = 3'h0;
        key_col = 4'h0;
        gpi_pin = 18'h00000;
        repeat (2) @(negedge clk);
        nrst = 1'b1;
        // link reset kept longer so it sees enough of its own edges
        repeat (3) @(posedge link_clk);
        #1;
        link_nrst = 1'b1;
        rd(kef_pkg::ADDR_CFG, 8'h00);
        rd(kef_pkg::ADDR_STATUS, 8'h00);
        rd(kef_pkg::ADDR_COUNT, 8'h00);
        rd(kef_pkg::ADDR_HEAD, 8'h00);
        rd(8'h7f, 8'h00);
        $display("done: reset");
        // all rows and columns in the matrix, alerts still masked
        wr(kef_pkg::ADDR_MEMBER0, 8'hff);
        wr(kef_pkg::ADDR_MEMBER1, 8'hff);
        wr(kef_pkg::ADDR_MEMBER2, 8'h03);
        key_ev(tbl[0]);
        key_end();
        alert_is(1'b0);
        wr(kef_pkg::ADDR_CFG, 8'h0b);
        alert_is(1'b1);
        for (int i = 1; i < 10; i++) begin
            key_ev(tbl[i]);
        end
        key_end();
        rd(kef_pkg::ADDR_STATUS, 8'h01);
        rd(kef_pkg::ADDR_COUNT, 8'h0a);
        // overflow dropped, then overflow evicting
        key_ev(8'h82);
        key_end();
        rd(kef_pkg::ADDR_STATUS, 8'h09);
        wr(kef_pkg::ADDR_CFG, 8'h2b);
        key_ev(8'h82);
        key_end();
        rd(kef_pkg::ADDR_COUNT, 8'h0a);
        for (int i = 1; i < 10; i++) begin
            rd(kef_pkg::ADDR_HEAD, tbl[i]);
            rd(kef_pkg::ADDR_COUNT, 8'(10 - i));
        end
        rd(kef_pkg::ADDR_HEAD, 8'h82);
        rd(kef_pkg::ADDR_COUNT, 8'h00);
        rd(kef_pkg::ADDR_HEAD, 8'h00);
        wr(kef_pkg::ADDR_STATUS, 8'h0b);
        rd(kef_pkg::ADDR_STATUS, 8'h00);
        alert_is(1'b0);
        $display("done: overflow");
        // column nine left out of the matrix
        wr(kef_pkg::ADDR_MEMBER2, 8'h01);
        key_ev(8'h93);
        key_end();
        rd(kef_pkg::ADDR_COUNT, 8'h00);
        // lock bit is stored only; the count field ignores writes
        wr(kef_pkg::ADDR_COUNT, 8'h4f);
        rd(kef_pkg::ADDR_COUNT, 8'h40);
        wr(kef_pkg::ADDR_COUNT, 8'h00);
        wr(kef_pkg::ADDR_MEMBER2, 8'h03);
        // random member keys, back to back
        for (int i = 0; i < 4; i++) begin
            r = $random(seed);
            rnd[i][7] = r[7];
            rnd[i][6:0] = 7'(r[2:0]) * 7'd10 + 7'(r[6:3] % 4'd10);
            key_ev(rnd[i]);
        end
        key_end();
        for (int i = 0; i < 4; i++) begin
            rd(kef_pkg::ADDR_HEAD, rnd[i]);
        end
        $display("done: matrix");
        // inputs: row0 and column9 enabled, row1 not
        wr(kef_pkg::ADDR_STATUS, 8'h0b);
        wr(kef_pkg::ADDR_MODE0, 8'h01);
        wr(kef_pkg::ADDR_MODE2, 8'h02);
        @(negedge clk);
        gpi_pin = 18'h20003;
        repeat (10) @(negedge clk);
        rd(kef_pkg::ADDR_STATUS, 8'h02);
        rd(kef_pkg::ADDR_COUNT, 8'h02);
        rd(kef_pkg::ADDR_HEAD, 8'he1);
        rd(kef_pkg::ADDR_HEAD, 8'hf2);
        $display("done: inputs");
        give_verdict();
    end
endmodule
`default_nettype wire
